// [rtl/vpc_pkg.sv]
// vpc_pkg: register indices, field layouts, reset values and carriers for the
// pixel capture unit. Assumes byte-addressed Avalon-MM with 32-bit data.
package vpc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_AUX      = 8'h00;
  localparam logic [7:0]  IDX_CTRL     = 8'h30;
  localparam logic [7:0]  IDX_POS      = 8'h31;
  localparam logic [7:0]  IDX_LINE     = 8'h32;
  localparam logic [7:0]  IDX_FIELD    = 8'h33;
  localparam logic [7:0]  IDX_STS      = 8'h34;
  localparam logic [7:0]  IDX_STATUS   = 8'h41;
  localparam logic [7:0]  IDX_CAP0     = 8'h50;
  localparam logic [3:0]  CAP_LAST     = 4'h8;
  localparam int          CAP_WORDS    = 9;

  // field values and reset values
  localparam logic [2:0]  AUX_FUNC_TRIG = 3'h6;
  localparam logic [2:0]  AUX_RST       = 3'h0;
  localparam logic [5:0]  CTRL_RST      = 6'h00;
  localparam logic [10:0] POS_RST       = 11'h000;
  localparam logic [9:0]  LINE_RST      = 10'h000;
  localparam logic [2:0]  FIELD_RST     = 3'h0;
  localparam logic [10:0] STS_RST       = 11'h35A;
  localparam logic [10:0] CAPTURE_LEAD  = 11'h01D;
  localparam logic [10:0] EXCESS_BASE   = 11'h600;
  localparam logic [8:0]  QUAD_TOP      = 9'h1FF;

  // status bit positions
  localparam int ST_PIX    = 0;
  localparam int ST_LINE   = 1;
  localparam int ST_FIELD  = 2;
  localparam int ST_STROBE = 3;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_LOAD = 2'b01,
    BUS_DONE = 2'b10
  } vpc_bus_e;

  typedef struct packed {
    logic pal_mode;
    logic gating_select;
    logic line_capture_external;
    logic line_capture_enable;
    logic external_trigger_enable;
    logic capture_enable;
  } vpc_ctrl_s;

  typedef struct packed {
    logic [9:0] address;
    logic       read;
    logic       write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } vpc_avm_req_s;

  typedef struct packed {
    logic [9:0] fmt_g;
    logic [9:0] fmt_b;
    logic [9:0] fmt_r;
    logic [9:0] luma_sync_bus;
    logic [9:0] uv_bus;
    logic       bus_slot;
  } vpc_video_s;

  typedef struct packed {
    logic       line_start;
    logic       field_start;
    logic [2:0] field_id;
  } vpc_timing_s;

endpackage : vpc_pkg

// [rtl/vpc_capture_store.sv]
// vpc_capture_store: nine captured bytes, written all at once, one registered
// read port. Assumes the caller holds raddr for the read it wants.
`timescale 1ns/10ps
module vpc_capture_store #(
  parameter int WORDS = 9
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 ce,
  // write side
  input  wire logic                 we,
  input  wire logic [WORDS*8-1:0]   wdata,
  // read side
  input  wire logic [3:0]           raddr,
  output logic      [7:0]           rdata
);
  logic [7:0] mem_ff [WORDS];
  logic [7:0] nxt_mem [WORDS];
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  always_comb begin
    for (int i = 0; i < WORDS; i++) begin
      nxt_mem[i] = we ? wdata[i*8 +: 8] : mem_ff[i];
    end
    nxt_rdata = (int'(raddr) < WORDS) ? mem_ff[raddr] : 8'h00;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_ff[i] <= 8'h00;
      end
      rdata_ff <= 8'h00;
    end else if (ce) begin
      mem_ff   <= nxt_mem;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;

  property p_hold;
    @(posedge clk) disable iff (!resetn)
      (ce && !we && $stable(raddr)) ##1 (ce && !we && $stable(raddr)) |=> $stable(rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("capture byte changed without a write");

endmodule : vpc_capture_store

// [rtl/vpc_capture_top.sv]
// vpc_capture_top: pixel capture unit with Avalon-MM register slave.
// Assumes video data and timing pulses are synchronous to clk (the pixel
// clock); only the auxiliary pin is asynchronous.
//
// Function
// - capture every line or once per sequence
// - aux falling edge triggers when function 110
// - colour in four bytes, grab in five
// - strobe delayed so components share pixel
// - compensate luma/sync and u/v multiplexing
// - internal strobe is pixel match or three-way AND
// - enable bits pick off, pixel, or AND
// - external mode follows inverted aux level
// - gating plus enable selects three-way AND
// - pixel and line matches compare counters, field match compares field_id input, with programmed values
// - gating low forces line and field match
// - match flags readable in status bits 0-2
// - position value leads captured pixel by 29
// - top bits quadrant, low nine offset
// - low bits: quadrant max minus quarter plus offset
// - pixel counter spans sync-to-sync count
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
module vpc_capture_top (
  // clock, reset, enable
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 ce,
  // avalon-mm slave
  input  wire vpc_pkg::vpc_avm_req_s avm,
  output logic      [31:0]          readdata,
  output logic                      waitrequest,
  // video side
  input  wire vpc_pkg::vpc_video_s  video,
  input  wire vpc_pkg::vpc_timing_s timing,
  input  wire logic                 aux_pin,
  // status
  output logic                      capture_strobe
);

  function automatic logic [10:0] pos_code(input logic [10:0] pix, input logic [10:0] sts);
    logic [10:0] q;
    logic [1:0]  quad;
    begin
      q = {2'b00, sts[10:2]};
      if (pix > 11'(q << 2)) begin
        pos_code = vpc_pkg::EXCESS_BASE + (pix - 11'(q << 2));
      end else begin
        if (pix < q) quad = 2'h0;
        else if (pix < 11'(q << 1)) quad = 2'h1;
        else if (pix < 11'(q * 3)) quad = 2'h2;
        else quad = 2'h3;
        pos_code = {quad, vpc_pkg::QUAD_TOP} - q + (pix - 11'({9'h000, quad} * q));
      end
    end
  endfunction : pos_code

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    begin
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    end
  endfunction : merge16

  // register file and bus
  vpc_pkg::vpc_bus_e  bus_ff, nxt_bus;
  vpc_pkg::vpc_ctrl_s ctrl_ff, nxt_ctrl;
  logic [2:0]  aux_func_ff, nxt_aux_func;
  logic [10:0] pos_ff, nxt_pos;
  logic [9:0]  line_sel_ff, nxt_line_sel;
  logic [2:0]  field_sel_ff, nxt_field_sel;
  logic [10:0] sts_ff, nxt_sts;
  logic [31:0] readdata_ff, nxt_readdata;
  // video side
  logic        aux_s1_ff, aux_s2_ff;
  logic        strobe_prev_ff, nxt_strobe_prev;
  logic [10:0] pix_cnt_ff, nxt_pix_cnt;
  logic [9:0]  line_cnt_ff, nxt_line_cnt;
  logic [9:0]  ls_h1_ff, ls_h2_ff, uv_h1_ff, uv_h2_ff;
  logic [29:0] fmt_h1_ff;
  logic        fire_d_ff, nxt_fire_d;
  logic        slot_ff, nxt_slot;
  // combinational
  logic [7:0]  idx;
  logic        req, take, in_cap;
  logic [3:0]  cap_raddr;
  logic [7:0]  cap_rdata;
  logic        pixel_match, line_match, field_match, ext_on, strobe, fire;
  logic [9:0]  luma_c, sync_c, u_c, v_c;
  logic [71:0] cap_wdata;

  assign idx       = avm.address[9:2];
  assign req       = avm.read | avm.write;
  assign take      = req && (bus_ff == vpc_pkg::BUS_DONE);
  assign in_cap    = (idx >= vpc_pkg::IDX_CAP0) && ((idx - vpc_pkg::IDX_CAP0) <= 8'(vpc_pkg::CAP_LAST));
  assign cap_raddr = in_cap ? 4'(idx - vpc_pkg::IDX_CAP0) : 4'h0;
  assign waitrequest = req && (bus_ff != vpc_pkg::BUS_DONE);
  assign readdata    = readdata_ff;

  // bus sequencing and register writes
  always_comb begin
    nxt_bus       = bus_ff;
    nxt_ctrl      = ctrl_ff;
    nxt_aux_func  = aux_func_ff;
    nxt_pos       = pos_ff;
    nxt_line_sel  = line_sel_ff;
    nxt_field_sel = field_sel_ff;
    nxt_sts       = sts_ff;
    nxt_readdata  = readdata_ff;
    case (bus_ff)
      vpc_pkg::BUS_IDLE: if (req) nxt_bus = vpc_pkg::BUS_LOAD;
      vpc_pkg::BUS_LOAD: begin
        // store read data is registered, hence the extra cycle
        nxt_bus      = vpc_pkg::BUS_DONE;
        nxt_readdata = 32'h0000_0000;
        if (in_cap) nxt_readdata = {24'h000000, cap_rdata};
        else case (idx)
          vpc_pkg::IDX_AUX:    nxt_readdata = {29'h0, aux_func_ff};
          vpc_pkg::IDX_CTRL:   nxt_readdata = {26'h0, ctrl_ff};
          vpc_pkg::IDX_POS:    nxt_readdata = {21'h0, pos_ff};
          vpc_pkg::IDX_LINE:   nxt_readdata = {22'h0, line_sel_ff};
          vpc_pkg::IDX_FIELD:  nxt_readdata = {29'h0, field_sel_ff};
          vpc_pkg::IDX_STS:    nxt_readdata = {21'h0, sts_ff};
          vpc_pkg::IDX_STATUS: nxt_readdata = {28'h0, strobe, field_match, line_match,
                                               pixel_match};
          default:             nxt_readdata = 32'h0000_0000;
        endcase
      end
      vpc_pkg::BUS_DONE: begin
        nxt_bus = vpc_pkg::BUS_IDLE;
        if (avm.write) begin
          case (idx)
            vpc_pkg::IDX_AUX:   nxt_aux_func  = 3'(merge16(16'(aux_func_ff), avm.writedata,
                                                           avm.byteenable));
            vpc_pkg::IDX_CTRL:  nxt_ctrl      = 6'(merge16(16'(ctrl_ff), avm.writedata,
                                                           avm.byteenable));
            vpc_pkg::IDX_POS:   nxt_pos       = 11'(merge16(16'(pos_ff), avm.writedata,
                                                            avm.byteenable));
            vpc_pkg::IDX_LINE:  nxt_line_sel  = 10'(merge16(16'(line_sel_ff), avm.writedata,
                                                            avm.byteenable));
            vpc_pkg::IDX_FIELD: nxt_field_sel = 3'(merge16(16'(field_sel_ff), avm.writedata,
                                                           avm.byteenable));
            vpc_pkg::IDX_STS:   nxt_sts       = 11'(merge16(16'(sts_ff), avm.writedata,
                                                            avm.byteenable));
            default:            nxt_bus       = vpc_pkg::BUS_IDLE;
          endcase
        end
      end
      default: nxt_bus = vpc_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_ff       <= vpc_pkg::BUS_IDLE;
      ctrl_ff      <= vpc_pkg::CTRL_RST;
      aux_func_ff  <= vpc_pkg::AUX_RST;
      pos_ff       <= vpc_pkg::POS_RST;
      line_sel_ff  <= vpc_pkg::LINE_RST;
      field_sel_ff <= vpc_pkg::FIELD_RST;
      sts_ff       <= vpc_pkg::STS_RST;
      readdata_ff  <= 32'h0000_0000;
    end else if (ce) begin
      bus_ff       <= nxt_bus;
      ctrl_ff      <= nxt_ctrl;
      aux_func_ff  <= nxt_aux_func;
      pos_ff       <= nxt_pos;
      line_sel_ff  <= nxt_line_sel;
      field_sel_ff <= nxt_field_sel;
      sts_ff       <= nxt_sts;
      readdata_ff  <= nxt_readdata;
    end
  end

  // match and strobe selection
  always_comb begin
    pixel_match = (pos_code(pix_cnt_ff, sts_ff) == pos_ff);
    // forced high when gating is off; ntsc sequence is four fields
    line_match  = !ctrl_ff.gating_select || (line_cnt_ff == line_sel_ff);
    field_match = !ctrl_ff.gating_select ||
                  (ctrl_ff.pal_mode ? (timing.field_id == field_sel_ff)
                                    : (timing.field_id[1:0] == field_sel_ff[1:0]));
    // pin only counts when its function selects the trigger
    ext_on = ctrl_ff.external_trigger_enable && (aux_func_ff == vpc_pkg::AUX_FUNC_TRIG);
    if (ctrl_ff.external_trigger_enable) strobe = ext_on && !aux_s2_ff;
    else if (ctrl_ff.line_capture_external) strobe = pixel_match;
    else if (!ctrl_ff.capture_enable) strobe = 1'b0;
    else if (ctrl_ff.line_capture_enable || ctrl_ff.gating_select)
      strobe = pixel_match && line_match && field_match;
    else strobe = pixel_match;
    // a held low pin would otherwise recapture every cycle
    fire = strobe && !strobe_prev_ff;
  end

  // counters, capture pipeline
  always_comb begin
    nxt_strobe_prev = strobe;
    // counter leads the data by the fixed lead
    // the load lands one cycle after the pixel-0 cycle, hence lead plus one
    if (timing.line_start) nxt_pix_cnt = vpc_pkg::CAPTURE_LEAD + 11'h001;
    else if (pix_cnt_ff >= sts_ff - 11'h001) nxt_pix_cnt = 11'h000;
    else nxt_pix_cnt = pix_cnt_ff + 11'h001;
    if (timing.field_start) nxt_line_cnt = 10'h000;
    else if (timing.line_start) nxt_line_cnt = line_cnt_ff + 10'h001;
    else nxt_line_cnt = line_cnt_ff;
    nxt_fire_d = fire;
    nxt_slot   = video.bus_slot;
    // pick the pair around the strobe from the two-cycle history
    if (!slot_ff) begin
      luma_c = ls_h1_ff;
      sync_c = video.luma_sync_bus;
      u_c    = uv_h1_ff;
      v_c    = video.uv_bus;
    end else begin
      luma_c = ls_h2_ff;
      sync_c = ls_h1_ff;
      u_c    = uv_h2_ff;
      v_c    = uv_h1_ff;
    end
    // upper eight bits per byte, low bit pairs gathered in a last byte
    cap_wdata = {luma_c[1:0], sync_c[1:0], u_c[1:0], v_c[1:0],
                 v_c[9:2], u_c[9:2], sync_c[9:2], luma_c[9:2],
                 2'b00, fmt_h1_ff[21:20], fmt_h1_ff[11:10], fmt_h1_ff[1:0],
                 fmt_h1_ff[9:2], fmt_h1_ff[19:12], fmt_h1_ff[29:22]};
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aux_s1_ff      <= 1'b1;
      aux_s2_ff      <= 1'b1;
      strobe_prev_ff <= 1'b0;
      pix_cnt_ff     <= 11'h000;
      line_cnt_ff    <= 10'h000;
      ls_h1_ff       <= 10'h000;
      ls_h2_ff       <= 10'h000;
      uv_h1_ff       <= 10'h000;
      uv_h2_ff       <= 10'h000;
      fmt_h1_ff      <= 30'h0000_0000;
      fire_d_ff      <= 1'b0;
      slot_ff        <= 1'b0;
    end else if (ce) begin
      aux_s1_ff      <= aux_pin;
      aux_s2_ff      <= aux_s1_ff;
      strobe_prev_ff <= nxt_strobe_prev;
      pix_cnt_ff     <= nxt_pix_cnt;
      line_cnt_ff    <= nxt_line_cnt;
      ls_h1_ff       <= video.luma_sync_bus;
      ls_h2_ff       <= ls_h1_ff;
      uv_h1_ff       <= video.uv_bus;
      uv_h2_ff       <= uv_h1_ff;
      fmt_h1_ff      <= {video.fmt_g, video.fmt_b, video.fmt_r};
      fire_d_ff      <= nxt_fire_d;
      slot_ff        <= nxt_slot;
    end
  end

  vpc_capture_store #(
    .WORDS (vpc_pkg::CAP_WORDS)
  ) u_store (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .we     (fire_d_ff),
    .wdata  (cap_wdata),
    .raddr  (cap_raddr),
    .rdata  (cap_rdata)
  );

  assign capture_strobe = strobe;

  property p_off;
    @(posedge clk) disable iff (!resetn)
      (!ctrl_ff.line_capture_external && !ctrl_ff.capture_enable &&
       !ctrl_ff.external_trigger_enable) |-> !capture_strobe;
  endproperty
  a_off: assert property (p_off) else $error("strobe active while disabled");
  property p_ext;
    @(posedge clk) disable iff (!resetn)
      ext_on |-> (capture_strobe == !aux_s2_ff);
  endproperty
  a_ext: assert property (p_ext) else $error("external strobe not inverted pin");
  property p_lext;
    @(posedge clk) disable iff (!resetn)
      (ctrl_ff.line_capture_external && !ctrl_ff.external_trigger_enable)
        |-> (capture_strobe == pixel_match);
  endproperty
  a_lext: assert property (p_lext) else $error("line external strobe wrong");
  property p_and;
    @(posedge clk) disable iff (!resetn)
      (ctrl_ff.capture_enable && ctrl_ff.gating_select && !ctrl_ff.line_capture_external &&
       !ctrl_ff.external_trigger_enable) |-> (capture_strobe == (pixel_match &&
       (line_cnt_ff == line_sel_ff) && field_match));
  endproperty
  a_and: assert property (p_and) else $error("gated strobe is not the three-way and");
  property p_force;
    @(posedge clk) disable iff (!resetn)
      !ctrl_ff.gating_select |-> (line_match && field_match);
  endproperty
  a_force: assert property (p_force) else $error("line or field match not forced");
  property p_lead;
    @(posedge clk) disable iff (!resetn)
      (ce && timing.line_start) |=> (pix_cnt_ff == vpc_pkg::CAPTURE_LEAD + 11'h001);
  endproperty
  a_lead: assert property (p_lead) else $error("pixel counter lead wrong");
  property p_wrap;
    @(posedge clk) disable iff (!resetn)
      (ce && !timing.line_start && pix_cnt_ff == sts_ff - 11'h001) |=> (pix_cnt_ff == 11'h000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("pixel counter did not wrap");
  property p_excess;
    @(posedge clk) disable iff (!resetn)
      (pix_cnt_ff > {sts_ff[10:2], 2'b00}) |->
        (pos_code(pix_cnt_ff, sts_ff) == vpc_pkg::EXCESS_BASE + pix_cnt_ff - {sts_ff[10:2], 2'b00});
  endproperty
  a_excess: assert property (p_excess) else $error("excess position code wrong");
  property p_capture;
    @(posedge clk) disable iff (!resetn)
      (ce && fire) ##1 ce |-> u_store.we;
  endproperty
  a_capture: assert property (p_capture) else $error("capture not written one cycle late");
  property p_answer;
    @(posedge clk) disable iff (!resetn)
      (ce && req && bus_ff == vpc_pkg::BUS_IDLE) ##1 (ce && req) ##1 req |-> !waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");

  c_int:  cover property (@(posedge clk) disable iff (!resetn)
                          fire && !ctrl_ff.external_trigger_enable);
  c_ext:  cover property (@(posedge clk) disable iff (!resetn) fire && ext_on);
  c_and:  cover property (@(posedge clk) disable iff (!resetn) fire && ctrl_ff.gating_select);
  c_read: cover property (@(posedge clk) disable iff (!resetn) take && avm.read && in_cap);

endmodule : vpc_capture_top

// [tb/vpc_capture_top_test.sv]
// vpc_capture_top_test: self-checking bench for the pixel capture unit.
// Assumes the top answers Avalon-MM with waitrequest and video runs on clk.
`timescale 1ns/10ps
module vpc_capture_top_test;
  localparam int LINES = 4;

  logic                  clk;
  logic                  resetn;
  logic                  ce;
  logic                  aux_pin;
  vpc_pkg::vpc_avm_req_s avm;
  vpc_pkg::vpc_video_s   video;
  vpc_pkg::vpc_timing_s  timing;
  logic [31:0]           readdata;
  logic                  waitrequest;
  logic                  capture_strobe;
  logic                  strobe_q;
  logic [31:0]           rd;
  int                    num_errors;
  int                    comparisons;
  int                    cycles;
  int                    strobes;
  int                    sts;
  int                    pix;
  int                    line;
  int                    fld;

  vpc_capture_top u_vpc_capture_top (
    .clk            (clk),
    .resetn         (resetn),
    .ce             (ce),
    .avm            (avm),
    .readdata       (readdata),
    .waitrequest    (waitrequest),
    .video          (video),
    .timing         (timing),
    .aux_pin        (aux_pin),
    .capture_strobe (capture_strobe)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // each pixel and each mux pair gets a distinct value, so a wrong pixel shows
  function automatic logic [9:0] pat(input int k, input int a, input int b);
    return 10'(k * a + b);
  endfunction : pat

  function automatic logic [10:0] code(input int c, input int s);
    int q;
    int qd;
    q = s / 4;
    if (c > 4 * q) return 11'(1536 + c - 4 * q);
    qd = (c < q) ? 0 : (c < 2 * q) ? 1 : (c < 3 * q) ? 2 : 3;
    return 11'(qd * 512 + 511 - q + c - qd * q);
  endfunction : code

  // video source: luma/sync and u/v alternate on the shared buses each cycle
  always @(posedge clk) begin
    cycles              <= cycles + 1;
    video.fmt_g         <= pat(pix, 3, 1);
    video.fmt_b         <= pat(pix, 5, 2);
    video.fmt_r         <= pat(pix, 7, 3);
    video.bus_slot      <= 1'(pix % 2);
    video.luma_sync_bus <= (pix % 2 == 1) ? pat(pix / 2, 2, 170) : pat(pix / 2, 1, 341);
    video.uv_bus        <= (pix % 2 == 1) ? pat(pix / 2, 3, 240) : pat(pix / 2, -1, 768);
    timing.line_start   <= (pix == 0);
    timing.field_start  <= (pix == 0 && line == 0);
    timing.field_id     <= 3'(fld);
    strobe_q            <= capture_strobe;
    if (capture_strobe === 1'b1 && strobe_q !== 1'b1) strobes <= strobes + 1;
    // wrap on >= so a shorter line length never strands the counter
    if (pix >= sts - 1) begin
      pix <= 0;
      line <= (line == LINES - 1) ? 0 : line + 1;
      if (line == LINES - 1) fld <= (fld + 1) % 8;
    end else begin
      pix <= pix + 1;
    end
    if (cycles == 60000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_n(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      num_errors++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_n

  // one register access; entered and left just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    avm.address    <= {idx, 2'b00};
    avm.writedata  <= wd;
    avm.byteenable <= 4'hF;
    avm.write      <= wr;
    avm.read       <= ~wr;
    // waitrequest is judged at the rising edge where the write lands and data is taken
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    if (waitrequest !== 1'b0) chk_n(n, 0);
    rd = readdata;
    avm.read  <= 1'b0;
    avm.write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wait_gen(input int f, input int l, input int p);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(fld == f && line == l && pix == p) && n < 5000);
    if (n >= 5000) chk_n(n, 0);
  endtask : wait_gen

  task automatic t_reset();
    bus(1'b0, vpc_pkg::IDX_CTRL, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, vpc_pkg::IDX_STS, 32'h0);
    chk(rd, {21'h0, vpc_pkg::STS_RST});
    bus(1'b0, vpc_pkg::IDX_CAP0, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 8'h7F, 32'hFFFF);
    chk(rd, 32'h0);
    bus(1'b1, vpc_pkg::IDX_POS, 32'h0000_07FF);
    bus(1'b0, vpc_pkg::IDX_POS, 32'h0);
    chk(rd, 32'h0000_07FF);
  endtask : t_reset

  task automatic t_grab(input int s, input int p);
    int   c;
    int   n0;
    logic [9:0] g, b, r, l, sy, u, v;
    logic [7:0] e [9];
    c = (p + 29) % s;
    sts <= s;
    bus(1'b1, vpc_pkg::IDX_STS, 32'(s));
    bus(1'b1, vpc_pkg::IDX_POS, 32'(code(c, s)));
    bus(1'b1, vpc_pkg::IDX_CTRL, 32'h01);
    wait_gen(0, 0, 0);
    n0 = strobes;
    repeat (LINES * s) @(posedge clk);
    chk_n(strobes - n0, LINES);
    bus(1'b1, vpc_pkg::IDX_CTRL, 32'h00);
    g  = pat(p, 3, 1);
    b  = pat(p, 5, 2);
    r  = pat(p, 7, 3);
    l  = pat(p / 2, 1, 341);
    sy = pat(p / 2, 2, 170);
    u  = pat(p / 2, -1, 768);
    v  = pat(p / 2, 3, 240);
    e  = '{g[9:2], b[9:2], r[9:2], {2'b00, g[1:0], b[1:0], r[1:0]}, l[9:2], sy[9:2],
           u[9:2], v[9:2], {l[1:0], sy[1:0], u[1:0], v[1:0]}};
    for (int i = 0; i < vpc_pkg::CAP_WORDS; i++) begin
      bus(1'b0, vpc_pkg::IDX_CAP0 + 8'(i), 32'h0);
      chk(rd, {24'h0, e[i]});
    end
    repeat (s) @(posedge clk);
    bus(1'b0, vpc_pkg::IDX_CAP0 + 8'h8, 32'h0);
    chk(rd, {24'h0, e[8]});
  endtask : t_grab

  task automatic t_select();
    logic [5:0] cv [6];
    int         ex [6];
    int         n0;
    cv = '{6'h00, 6'h01, 6'h31, 6'h25, 6'h11, 6'h08};
    // gating low forces line and field match, so line enable alone fires every line
    ex = '{0, 8 * LINES, 1, 8 * LINES, 2, 8 * LINES};
    sts <= 64;
    bus(1'b1, vpc_pkg::IDX_STS, 32'd64);
    bus(1'b1, vpc_pkg::IDX_POS, 32'(code(34, 64)));
    bus(1'b1, vpc_pkg::IDX_LINE, 32'd2);
    bus(1'b1, vpc_pkg::IDX_FIELD, 32'd3);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, vpc_pkg::IDX_CTRL, {26'h0, cv[i]});
      wait_gen(0, 0, 0);
      n0 = strobes;
      repeat (8 * LINES * 64) @(posedge clk);
      chk_n(strobes - n0, ex[i]);
    end
  endtask : t_select

  task automatic t_status();
    bus(1'b1, vpc_pkg::IDX_CTRL, 32'h31);
    // status is sampled one cycle after the request shows, on pixel 5 here
    wait_gen(3, 2, 4);
    bus(1'b0, vpc_pkg::IDX_STATUS, 32'h0);
    chk({29'h0, rd[2:0]}, 32'h7);
    wait_gen(3, 3, 5);
    bus(1'b0, vpc_pkg::IDX_STATUS, 32'h0);
    chk({30'h0, rd[2:1]}, 32'h2);
    bus(1'b1, vpc_pkg::IDX_CTRL, 32'h01);
    wait_gen(0, 0, 5);
    bus(1'b0, vpc_pkg::IDX_STATUS, 32'h0);
    chk({30'h0, rd[2:1]}, 32'h3);
  endtask : t_status

  task automatic t_external();
    int n0;
    bus(1'b1, vpc_pkg::IDX_AUX, {29'h0, vpc_pkg::AUX_FUNC_TRIG});
    bus(1'b1, vpc_pkg::IDX_CTRL, 32'h03);
    repeat (4) @(posedge clk);
    chk({31'h0, capture_strobe}, 32'h0);
    n0 = strobes;
    aux_pin <= 1'b0;
    repeat (16) @(posedge clk);
    chk({31'h0, capture_strobe}, 32'h1);
    chk_n(strobes - n0, 1);
    aux_pin <= 1'b1;
    repeat (8) @(posedge clk);
    chk({31'h0, capture_strobe}, 32'h0);
    // pin function other than trigger must not capture
    bus(1'b1, vpc_pkg::IDX_AUX, 32'h0);
    n0 = strobes;
    aux_pin <= 1'b0;
    repeat (8) @(posedge clk);
    chk_n(strobes - n0, 0);
    aux_pin <= 1'b1;
    bus(1'b1, vpc_pkg::IDX_CTRL, 32'h0);
  endtask : t_external

  initial begin
    avm         = '0;
    video       = '0;
    timing      = '0;
    aux_pin     = 1'b1;
    ce          = 1'b1;
    resetn      = 1'b0;
    strobe_q    = 1'b0;
    num_errors  = 0;
    comparisons = 0;
    cycles      = 0;
    strobes     = 0;
    sts         = 64;
    pix         = 0;
    line        = 0;
    fld         = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_grab(64, 5);
    t_grab(64, 0);
    t_grab(66, 36);
    t_select();
    t_status();
    t_external();
    test_done();
  end
endmodule : vpc_capture_top_test
